// >>> verilog/ledport_cfg.svh
// Constants of the serial load port of the LED driver
`ifndef LEDPORT_CFG_SVH
`define LEDPORT_CFG_SVH
`define WORD_BITS          16
`define CHAIN_DELAY_EDGES  16
`define FIFO_DEPTH_WORDS   16
`define SYS_CLK_PERIOD_NS  50
`define SCLK_MAX_MHZ       10
`define SCLK_MIN_PERIOD_NS (1000 / `SCLK_MAX_MHZ)
`define SCLK_MIN_CYCLES    \
  ((`SCLK_MIN_PERIOD_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define BLANK_AT_RESET     1'h1
`endif

// >>> verilog/ledport_pkg.sv
// Types of the serial load port of the LED driver
package ledport_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0]
  {
    DISP_BLANK   = 2'h0,
    DISP_ON      = 2'h1,
    DISP_SHUTOFF = 2'h2
  } disp_state_t;
endpackage : ledport_pkg

// >>> verilog/led_serial_load_port.sv
// Serial load port with word FIFO and display enable state
`include "ledport_cfg.svh"

module word_fifo #(
  parameter int WIDTH = `WORD_BITS,
  parameter int DEPTH = `FIFO_DEPTH_WORDS
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wr_next  = push ? bump(wr_reg) : wr_reg;
    rd_next  = pop ? bump(rd_reg) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    else if (pop && !push)
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
endmodule : word_fifo

// How it works
// R1 - Each rising shift clock edge moves serial input into a 16-bit register.
// R2 - Shifting happens only while the load strobe is low.
// R3 - Load strobe rising edge captures the last 16 shifted bits as the word.
// R4 - Serial output changes only on the rising shift clock edge.
// R5 - Serial output repeats serial input exactly 16 shift edges later.
// R6 - Serial output is always driven, never released.
// R7 - Host keeps the shift clock at or below 10 MHz.
// R8 - Display stays blanked after reset until a word has been loaded.
// R9 - Shutdown only blanks the display; shifting, latching and FIFO writes go on.
// R10 - Each latched word that finds room becomes one single-cycle write into the word FIFO.
module led_serial_load_port #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_WORDS
) (
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                shift_clk,
  input  wire logic                serial_in,
  input  wire logic                load_strobe,
  output logic                     serial_out,
  input  wire logic                shutdown,
  output logic                     display_on,
  output ledport_pkg::disp_state_t disp_state,
  output logic                     word_valid,
  input  wire logic                word_ready,
  output ledport_pkg::word_t       word_data,
  output logic                     overflow
);
  logic [2:0]               sclk_sync_reg;
  logic [1:0]               sin_sync_reg;
  logic [2:0]               ld_sync_reg;
  logic                     sclk_rise;
  logic                     ld_rise;
  logic                     ld_low;
  ledport_pkg::word_t       shift_reg;
  ledport_pkg::word_t       shift_next;
  logic                     serial_out_reg;
  logic                     serial_out_next;
  ledport_pkg::word_t       latch_reg;
  ledport_pkg::word_t       latch_next;
  logic                     push_reg;
  logic                     push_next;
  logic                     overflow_reg;
  logic                     overflow_next;
  ledport_pkg::disp_state_t state_reg;
  ledport_pkg::disp_state_t state_next;
  logic                     display_on_reg;
  logic                     display_on_next;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  ledport_pkg::word_t       fifo_out_data;
  logic                     fifo_out_ready;
  logic                     out_valid_reg;
  logic                     out_valid_next;
  ledport_pkg::word_t       out_data_reg;
  ledport_pkg::word_t       out_data_next;

  // Stage 1 of each synchroniser feeds only stage 2
  assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  assign ld_rise   = ld_sync_reg[1] && !ld_sync_reg[2];
  assign ld_low    = !ld_sync_reg[1];
  assign fifo_out_ready = !out_valid_reg || word_ready;

  always_comb
  begin
    shift_next      = shift_reg;
    serial_out_next = serial_out_reg;
    latch_next      = latch_reg;
    push_next       = 1'b0;
    overflow_next   = overflow_reg;
    if (sclk_rise && ld_low) // R2
    begin
      shift_next      = {shift_reg[14:0], sin_sync_reg[1]}; // R1
      serial_out_next = shift_reg[15]; // R4 R5
    end
    if (ld_rise)
    begin
      latch_next = shift_reg; // R3
      // Host cannot be stalled, so a full FIFO drops and flags
      if (fifo_in_ready)
        push_next = 1'b1; // R10
      else
        overflow_next = 1'b1;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ledport_pkg::DISP_BLANK:
        if (push_reg)
          state_next = shutdown ? ledport_pkg::DISP_SHUTOFF
                                : ledport_pkg::DISP_ON; // R8
      ledport_pkg::DISP_ON:
        if (shutdown)
          state_next = ledport_pkg::DISP_SHUTOFF;
      ledport_pkg::DISP_SHUTOFF:
        if (!shutdown)
          state_next = ledport_pkg::DISP_ON; // R9
      default:
        state_next = ledport_pkg::DISP_BLANK;
    endcase
    display_on_next = (state_next == ledport_pkg::DISP_ON);
  end

  always_comb
  begin
    out_valid_next = out_valid_reg;
    out_data_next  = out_data_reg;
    if (fifo_out_ready)
    begin
      out_valid_next = fifo_out_valid;
      out_data_next  = fifo_out_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      sclk_sync_reg  <= 3'h0;
      sin_sync_reg   <= 2'h0;
      ld_sync_reg    <= 3'h7;
      shift_reg      <= 16'h0000;
      serial_out_reg <= 1'h0;
      latch_reg      <= 16'h0000;
      push_reg       <= 1'h0;
      overflow_reg   <= 1'h0;
      state_reg      <= ledport_pkg::DISP_BLANK;
      display_on_reg <= !`BLANK_AT_RESET;
      out_valid_reg  <= 1'h0;
      out_data_reg   <= 16'h0000;
    end
    else
    begin
      sclk_sync_reg  <= {sclk_sync_reg[1:0], shift_clk};
      sin_sync_reg   <= {sin_sync_reg[0], serial_in};
      ld_sync_reg    <= {ld_sync_reg[1:0], load_strobe};
      shift_reg      <= shift_next;
      serial_out_reg <= serial_out_next;
      latch_reg      <= latch_next;
      push_reg       <= push_next;
      overflow_reg   <= overflow_next;
      state_reg      <= state_next;
      display_on_reg <= display_on_next;
      out_valid_reg  <= out_valid_next;
      out_data_reg   <= out_data_next;
    end
  end

  word_fifo #(
    .WIDTH (`WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (latch_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Plain output, no enable: never released
  assign serial_out = serial_out_reg; // R6
  assign display_on = display_on_reg;
  assign disp_state = state_reg;
  assign word_valid = out_valid_reg;
  assign word_data  = out_data_reg;
  assign overflow   = overflow_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_SHIFT: assert property (sclk_rise && ld_low |=> // R1
    shift_reg == {$past(shift_reg[14:0]), $past(sin_sync_reg[1])})
    else $error("shift register did not take the input bit");
  AST_HOLD_HIGH: assert property (sclk_rise && !ld_low |=> // R2
    $stable(shift_reg))
    else $error("shift register moved while load strobe high");
  AST_LATCH: assert property (ld_rise |=> // R3
    latch_reg == $past(shift_reg))
    else $error("latched word is not the last shifted word");
  AST_OUT_EDGE: assert property (!sclk_rise |=> // R4
    $stable(serial_out_reg))
    else $error("serial output changed without a shift edge");
  AST_CHAIN: assert property (sclk_rise && ld_low |=> // R5
    serial_out_reg == $past(shift_reg[15]))
    else $error("serial output is not the bit shifted 16 edges ago");
  AST_BLANK: assert property (state_reg == ledport_pkg::DISP_BLANK |=> // R8
    !display_on_reg || $past(push_reg))
    else $error("display lit before any word was loaded");
  // New words may still be loaded during shutdown; otherwise the latched word holds and the display stays dark
  AST_RETAIN: assert property (shutdown && !ld_rise |=> // R9
    $stable(latch_reg) && !display_on_reg)
    else $error("state lost or display lit during shutdown");
  AST_PUSH_ONCE: assert property (ld_rise && fifo_in_ready |=> // R10
    push_reg ##1 !push_reg)
    else $error("latched word not written exactly once");

  COV_LATCH: cover property (ld_rise ##1 push_reg);
  COV_FULL:  cover property (!fifo_in_ready);
  COV_OVFL:  cover property ($rose(overflow_reg));
  COV_SHUT:  cover property (state_reg == ledport_pkg::DISP_SHUTOFF
    ##1 state_reg == ledport_pkg::DISP_ON);
endmodule : led_serial_load_port

// >>> verif/host_model.sv
// Host model that shifts words into the serial load port
module host_model (
  input  wire logic   sys_clk,
  input  wire logic   serial_out,
  output logic        shift_clk,
  output logic        serial_in,
  output logic        load_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  ledport_pkg::word_t echo;

  initial
  begin
    shift_clk   = 1'h0;
    serial_in   = 1'h0;
    load_strobe = 1'h1;
    echo        = 16'h0000;
  end

  // Four cycles a phase gives 400 ns, inside the 10 MHz limit
  task automatic send(input logic [31:0] d, input int n, input logic latch);
    for (int i = n - 1; i >= 0; i--)
    begin
      load_strobe <= ~latch;
      serial_in   <= d[i];
      repeat (4) @(posedge sys_clk);
      shift_clk   <= 1'h1;
      repeat (4) @(posedge sys_clk);
      if (latch)
        echo <= {echo[14:0], serial_out};
      shift_clk   <= 1'h0;
    end
    repeat (4) @(posedge sys_clk);
    // Released line shows the inverse, not a stale bit
    serial_in   <= ~serial_in;
    load_strobe <= 1'h1;
    repeat (8) @(posedge sys_clk);
  endtask : send
endmodule : host_model

// >>> verif/testbench.sv
// Self-checking bench of the serial load port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] d; int n; ledport_pkg::word_t w;} row_t;
  logic sys_clk, rstn, shift_clk, serial_in, load_strobe, serial_out;
  logic shutdown, display_on, word_valid, word_ready, overflow;
  ledport_pkg::disp_state_t disp_state;
  ledport_pkg::word_t       word_data;
  logic [47:0]              hist;
  int                       mismatches, n_compared;
  row_t rows [5] = '{'{32'h00001234, 16, 16'h1234},
    '{32'h0000FFFF, 16, 16'hFFFF}, '{32'h00000000, 16, 16'h0000},
    '{32'h000ABCDE, 20, 16'hBCDE}, '{32'h00008001, 16, 16'h8001}};

  host_model u_host (.sys_clk(sys_clk), .serial_out(serial_out),
    .shift_clk(shift_clk), .serial_in(serial_in),
    .load_strobe(load_strobe));
  led_serial_load_port u_dut (.sys_clk(sys_clk), .rstn(rstn),
    .shift_clk(shift_clk), .serial_in(serial_in),
    .load_strobe(load_strobe), .serial_out(serial_out),
    .shutdown(shutdown), .display_on(display_on),
    .disp_state(disp_state), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .overflow(overflow));

  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic put(input logic [31:0] d, input int n, input logic latch);
    u_host.send(d, n, latch);
    if (latch)
      for (int i = n - 1; i >= 0; i--)
        hist = {hist[46:0], d[i]};
    check("serial_out", u_host.echo, hist[31:16]);
  endtask : put

  task automatic take(input ledport_pkg::word_t exp);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (word_valid !== 1'h1 && k < 40)
    begin
      @(negedge sys_clk);
      k++;
    end
    check("word_valid", word_valid, 1'h1);
    check("word_data", word_data, exp);
    @(posedge sys_clk);
    word_ready <= 1'h1;
    @(posedge sys_clk);
    word_ready <= 1'h0;
  endtask : take

  task automatic idle_checks();
    @(negedge sys_clk);
    check("display_on", display_on, 1'h0);
    check("disp_state", disp_state, ledport_pkg::DISP_BLANK);
    check("valid_overflow_out", {word_valid, overflow, serial_out}, 3'h0);
  endtask : idle_checks

  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial
  begin
    #1000000;
    mismatches++;
    wrap_up();
  end

  initial
  begin
    rstn = 1'h0;
    shutdown = 1'h0;
    word_ready = 1'h0;
    hist = 48'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'h1;
    idle_checks();
    repeat (4) @(posedge sys_clk);
    foreach (rows[i])
    begin
      put(rows[i].d, rows[i].n, 1'h1);
      take(rows[i].w);
    end
    check("display_on", display_on, 1'h1);
    // Shifts with the strobe high must leave the register alone
    put(32'h0000000F, 4, 1'h0);
    put(32'h0000003C, 8, 1'h1);
    take(16'h013C);
    @(posedge sys_clk);
    shutdown <= 1'h1;
    repeat (3) @(negedge sys_clk);
    check("disp_state", disp_state, ledport_pkg::DISP_SHUTOFF);
    check("display_on", display_on, 1'h0);
    put(32'h0000C3C3, 16, 1'h1);
    take(16'hC3C3);
    @(posedge sys_clk);
    shutdown <= 1'h0;
    repeat (3) @(negedge sys_clk);
    check("disp_state", disp_state, ledport_pkg::DISP_ON);
    check("display_on", display_on, 1'h1);
    // Consumer stalls while the host overruns the FIFO
    for (int j = 0; j < 18; j++)
      put(j, 16, 1'h1);
    check("overflow", overflow, 1'h1);
    for (int j = 0; j < 16; j++)
      take(ledport_pkg::word_t'(j));
    check("overflow", overflow, 1'h1);
    @(posedge sys_clk);
    rstn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'h1;
    idle_checks();
    wrap_up();
  end
endmodule : testbench
